// ==== hw/mpis_pkg.sv ====
package mpis_pkg;
    // ----------------------------------------------------------------
    // command encodings on the memory command pins
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MPIS_CMD_NOP,
        MPIS_CMD_MRL,
        MPIS_CMD_REF,
        MPIS_CMD_ACC
    } mpis_cmd_t;

    localparam int MPIS_BANKS = 8;
    localparam int MPIS_BANK_W = 3;
    localparam int MPIS_ADDR_W = 22;
    localparam int MPIS_HALF_W = 11;
    localparam int MPIS_MODE_W = 18;
    localparam int MPIS_CNT_W = 16;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int MPIS_CLK_MHZ = 25;
    localparam int MPIS_STABLE_US = 200;
    localparam int MPIS_STABLE_CYC = MPIS_STABLE_US * MPIS_CLK_MHZ;
    localparam int MPIS_IDLE_CMDS = 1024;
    localparam int MPIS_DLL_LOCK_CYC = 1024;
    localparam int MPIS_DUMMY_LOADS = 2;
    localparam int MPIS_MRSC_CYC = 6;
    localparam int MPIS_RC_CYC = 8;
    localparam int MPIS_WR_RD_GAP = 2;
    localparam int MPIS_RDLAT_CYC = 9;
    localparam int MPIS_WRLAT_CYC = MPIS_RDLAT_CYC + 1;

    // ----------------------------------------------------------------
    // mode word fields
    // ----------------------------------------------------------------
    localparam int MPIS_LOOP_RESET_POS = 7;
    localparam logic [MPIS_MODE_W-1:0] MPIS_MODE_RST = 18'h00000;
endpackage

// ==== hw/mpis_bank_if.sv ====
`timescale 1ns/1ps
interface mpis_bank_if;
    logic start;
    logic busy;
    modport ctl (output start, input busy);
    modport tmr (input start, output busy);
endinterface

// ==== hw/mpis_bank_timer.sv ====
`timescale 1ns/1ps
module mpis_bank_timer #(
    parameter int RC_CYC = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    mpis_bank_if.tmr bif
);
    localparam logic [7:0] RC_LOAD = 8'(RC_CYC - 1);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    assign cnt_nxt = bif.start ? RC_LOAD : (cnt_r != 8'h00 ? cnt_r - 8'h01 : 8'h00);
    assign bif.busy = (cnt_r != 8'h00);
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // mpis_bank_timer

// ==== hw/mpis_sequencer.sv ====
`timescale 1ns/1ps
module mpis_sequencer
    import mpis_pkg::*;
#(
    parameter int STABLE_CYC = mpis_pkg::MPIS_STABLE_CYC,
    parameter int DLL_LOCK_CYC = mpis_pkg::MPIS_DLL_LOCK_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [mpis_pkg::MPIS_MODE_W-1:0] mode_word,
    input wire logic clk_change,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [mpis_pkg::MPIS_BANK_W-1:0] req_bank,
    input wire logic [mpis_pkg::MPIS_ADDR_W-1:0] req_addr,
    output logic req_ready,
    output logic init_done,
    output logic mem_clk_en,
    output mpis_pkg::mpis_cmd_t mem_cmd,
    output logic mem_we,
    output logic [mpis_pkg::MPIS_BANK_W-1:0] mem_bank,
    output logic [mpis_pkg::MPIS_MODE_W-1:0] mem_addr,
    output logic wdata_start
);
    import mpis_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        S_STABLE, S_DUMMY, S_VALID, S_SETTLE, S_REFRESH, S_IDLES,
        S_RUN, S_HALF2, S_DLL_LOW, S_DLL_SET, S_DLL_HIGH, S_DLL_LOCK
    } mpis_state_t;

    mpis_state_t state_r, state_nxt;
    logic [MPIS_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [MPIS_BANK_W-1:0] bank_r, bank_nxt;
    logic last_wr_r, last_wr_nxt;
    logic [1:0] gap_r, gap_nxt;
    logic [MPIS_HALF_W-1:0] half2_r, half2_nxt;
    logic dll_pend_r, dll_pend_nxt;
    logic [MPIS_WRLAT_CYC-1:0] wpipe_r;
    mpis_cmd_t cmd_r, cmd_nxt;
    logic we_r, we_nxt;
    logic [MPIS_BANK_W-1:0] mbank_r, mbank_nxt;
    logic [MPIS_MODE_W-1:0] maddr_r, maddr_nxt;
    logic clk_en_r;

    localparam logic [MPIS_CNT_W-1:0] STABLE_LD = MPIS_CNT_W'(STABLE_CYC - 1);
    localparam logic [MPIS_CNT_W-1:0] DUMMY_LD = MPIS_CNT_W'(MPIS_DUMMY_LOADS - 1);
    localparam logic [MPIS_CNT_W-1:0] MRSC_LD = MPIS_CNT_W'(MPIS_MRSC_CYC - 1);
    localparam logic [MPIS_CNT_W-1:0] IDLE_LD = MPIS_CNT_W'(MPIS_IDLE_CMDS - 1);
    localparam logic [MPIS_CNT_W-1:0] LOCK_LD = MPIS_CNT_W'(DLL_LOCK_CYC - 1);
    localparam logic [MPIS_CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [MPIS_CNT_W-1:0] CNT_ONE = MPIS_CNT_W'(1);

    // ----------------------------------------------------------------
    // per-bank row cycle timers
    // ----------------------------------------------------------------
    mpis_bank_if bif [MPIS_BANKS] ();
    logic [MPIS_BANKS-1:0] bank_busy;
    logic [MPIS_BANKS-1:0] bank_start;

    genvar gi;
    generate
        for (gi = 0; gi < MPIS_BANKS; gi++) begin : g_bank
            assign bif[gi].start = bank_start[gi];
            assign bank_busy[gi] = bif[gi].busy;
            mpis_bank_timer #(.RC_CYC(MPIS_RC_CYC)) u_tmr (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .bif(bif[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire cnt_zero = (cnt_r == CNT_ZERO);
    wire req_bank_busy = bank_busy[req_bank];
    wire turn_block = req_valid && !req_write && last_wr_r && (gap_r != 2'd0);
    wire bank_block = req_bank_busy;
    wire run_ok = (state_r == S_RUN) && !dll_pend_r;
    wire acc_go = run_ok && req_valid && !bank_block && !turn_block;
    wire ref_go = (state_r == S_REFRESH);
    wire [MPIS_MODE_W-1:0] mode_lo = mode_word & ~(18'h00001 << MPIS_LOOP_RESET_POS);
    wire [MPIS_MODE_W-1:0] mode_hi = mode_word | (18'h00001 << MPIS_LOOP_RESET_POS);

    assign req_ready = acc_go;
    assign init_done = (state_r == S_RUN) || (state_r == S_HALF2);
    assign mem_clk_en = clk_en_r;
    assign mem_cmd = cmd_r;
    assign mem_we = we_r;
    assign mem_bank = mbank_r;
    assign mem_addr = maddr_r;
    // write data at read latency plus one
    assign wdata_start = wpipe_r[MPIS_WRLAT_CYC-1];

    // refresh or access starts bank timer
    generate
        for (gi = 0; gi < MPIS_BANKS; gi++) begin : g_start
            assign bank_start[gi] = (ref_go && bank_r == MPIS_BANK_W'(gi))
                || (acc_go && req_bank == MPIS_BANK_W'(gi));
        end
    endgenerate

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r != CNT_ZERO) ? cnt_r - CNT_ONE : CNT_ZERO;
        bank_nxt = bank_r;
        last_wr_nxt = last_wr_r;
        gap_nxt = (gap_r != 2'd0) ? gap_r - 2'd1 : 2'd0;
        half2_nxt = half2_r;
        dll_pend_nxt = dll_pend_r | clk_change;
        cmd_nxt = MPIS_CMD_NOP;
        we_nxt = 1'b0;
        mbank_nxt = '0;
        maddr_nxt = '0;
        case (state_r)
            S_STABLE: begin
                if (cnt_zero) begin
                    state_nxt = S_DUMMY;
                    cnt_nxt = DUMMY_LD;
                end
            end
            S_DUMMY: begin
                cmd_nxt = MPIS_CMD_MRL;
                if (cnt_zero) begin
                    state_nxt = S_VALID;
                end
            end
            S_VALID: begin
                cmd_nxt = MPIS_CMD_MRL;
                maddr_nxt = mode_hi;
                state_nxt = S_SETTLE;
                cnt_nxt = MRSC_LD;
            end
            S_SETTLE: begin
                if (cnt_zero) begin
                    state_nxt = S_REFRESH;
                    bank_nxt = '0;
                end
            end
            // refresh each bank; back to back
            S_REFRESH: begin
                cmd_nxt = MPIS_CMD_REF;
                mbank_nxt = bank_r;
                bank_nxt = bank_r + 3'd1;
                if (bank_r == 3'(MPIS_BANKS - 1)) begin
                    state_nxt = S_IDLES;
                    cnt_nxt = IDLE_LD - CNT_ONE * 16'(MPIS_BANKS);
                end
            end
            S_IDLES: begin
                if (cnt_zero) begin
                    state_nxt = S_RUN;
                    dll_pend_nxt = clk_change;
                end
            end
            S_RUN: begin
                if (dll_pend_r) begin
                    state_nxt = S_DLL_LOW;
                end else if (acc_go) begin
                    cmd_nxt = MPIS_CMD_ACC;
                    we_nxt = req_write;
                    mbank_nxt = req_bank;
                    maddr_nxt = {7'h00, req_addr[MPIS_HALF_W-1:0]};
                    half2_nxt = req_addr[MPIS_ADDR_W-1:MPIS_HALF_W];
                    last_wr_nxt = req_write;
                    gap_nxt = req_write ? 2'(MPIS_WR_RD_GAP + 1) : 2'd0;
                    state_nxt = S_HALF2;
                end
            end
            S_HALF2: begin
                maddr_nxt = {7'h00, half2_r};
                state_nxt = S_RUN;
            end
            S_DLL_LOW: begin
                cmd_nxt = MPIS_CMD_MRL;
                maddr_nxt = mode_lo;
                dll_pend_nxt = clk_change;
                cnt_nxt = MRSC_LD;
                state_nxt = S_DLL_SET;
            end
            S_DLL_SET: begin
                if (cnt_zero) begin
                    state_nxt = S_DLL_HIGH;
                end
            end
            // loop reset high, then lock wait
            S_DLL_HIGH: begin
                cmd_nxt = MPIS_CMD_MRL;
                maddr_nxt = mode_hi;
                cnt_nxt = LOCK_LD;
                state_nxt = S_DLL_LOCK;
            end
            S_DLL_LOCK: begin
                if (cnt_zero) begin
                    state_nxt = S_RUN;
                end
            end
            default: begin
                state_nxt = S_STABLE;
                cnt_nxt = STABLE_LD;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= S_STABLE;
            cnt_r <= STABLE_LD;
            bank_r <= '0;
            last_wr_r <= 1'b0;
            gap_r <= 2'd0;
            half2_r <= '0;
            dll_pend_r <= 1'b0;
            clk_en_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bank_r <= bank_nxt;
            last_wr_r <= last_wr_nxt;
            gap_r <= gap_nxt;
            half2_r <= half2_nxt;
            dll_pend_r <= dll_pend_nxt;
            clk_en_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_r <= MPIS_CMD_NOP;
            we_r <= 1'b0;
            mbank_r <= '0;
            maddr_r <= MPIS_MODE_RST;
            wpipe_r <= '0;
        end else begin
            cmd_r <= cmd_nxt;
            we_r <= we_nxt;
            mbank_r <= mbank_nxt;
            maddr_r <= maddr_nxt;
            // timed from the write on the pins, not from the accept
            wpipe_r <= {wpipe_r[MPIS_WRLAT_CYC-2:0], (cmd_r == MPIS_CMD_ACC) && we_r};
        end
    end
endmodule // mpis_sequencer

// ==== testbench/mpis_mem_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// memory device seen from its command pins
// ----------------------------------------------------------------
module mpis_mem_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic mem_clk_en,
    input wire mpis_pkg::mpis_cmd_t mem_cmd,
    input wire logic mem_we,
    input wire logic [mpis_pkg::MPIS_BANK_W-1:0] mem_bank,
    input wire logic [mpis_pkg::MPIS_MODE_W-1:0] mem_addr,
    input wire logic wdata_start,
    output logic [7:0] n_loads,
    output logic [7:0] n_refs,
    output logic [mpis_pkg::MPIS_ADDR_W-1:0] acc_addr,
    output logic [mpis_pkg::MPIS_MODE_W-1:0] mode_r,
    output logic [7:0] wlat
);
    import mpis_pkg::*;
    logic half_r;
    logic [7:0] wcnt_r;
    // commands count only while the command clock runs
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            {n_loads, n_refs, acc_addr, mode_r, wlat, wcnt_r, half_r} <= '0;
        end else if (mem_clk_en) begin
            half_r <= (mem_cmd == MPIS_CMD_ACC);
            wcnt_r <= (mem_cmd == MPIS_CMD_ACC && mem_we) ? 8'h01 : wcnt_r + 8'h01;
            if (mem_cmd == MPIS_CMD_MRL) begin
                n_loads <= n_loads + 8'h01;
                mode_r <= mem_addr;
            end
            if (mem_cmd == MPIS_CMD_REF) n_refs <= n_refs + 8'h01;
            if (mem_cmd == MPIS_CMD_ACC) acc_addr[10:0] <= mem_addr[10:0];
            if (half_r) acc_addr[21:11] <= mem_addr[10:0];
            if (wdata_start) wlat <= wcnt_r;
        end
    end
endmodule // mpis_mem_model

// ==== testbench/mpis_sequencer_chk.sv ====
`timescale 1ns/1ps
module mpis_sequencer_chk #(
    parameter int STABLE_CYC = 10,
    parameter int DLL_LOCK_CYC = 4
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [mpis_pkg::MPIS_MODE_W-1:0] mode_word,
    input wire logic clk_change,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [mpis_pkg::MPIS_BANK_W-1:0] req_bank,
    input wire logic [mpis_pkg::MPIS_ADDR_W-1:0] req_addr,
    input wire logic req_ready,
    input wire logic init_done,
    input wire logic mem_clk_en,
    input wire mpis_pkg::mpis_cmd_t mem_cmd,
    input wire logic mem_we,
    input wire logic [mpis_pkg::MPIS_BANK_W-1:0] mem_bank,
    input wire logic [mpis_pkg::MPIS_MODE_W-1:0] mem_addr,
    input wire logic wdata_start
);
    import mpis_pkg::*;
    // ----------------------------------------------------------------
    // helpers: cycles since reset, cycles since each bank was used
    // ----------------------------------------------------------------
    logic [15:0] cyc_r;
    logic [3:0] age_r [MPIS_BANKS];
    wire hit = (mem_cmd == MPIS_CMD_ACC) || (mem_cmd == MPIS_CMD_REF);
    wire acc = req_valid && req_ready;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cyc_r <= '0;
            for (int i = 0; i < MPIS_BANKS; i++) age_r[i] <= 4'hf;
        end else begin
            if (cyc_r != 16'hffff) cyc_r <= cyc_r + 16'h1;
            // saturate so an idle bank never looks busy again
            for (int i = 0; i < MPIS_BANKS; i++)
                age_r[i] <= (hit && mem_bank == 3'(i)) ? 4'h1 :
                    (age_r[i] == 4'hf) ? age_r[i] : age_r[i] + 4'h1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_idle;
        cyc_r != 0 && cyc_r < STABLE_CYC |-> mem_cmd == MPIS_CMD_NOP && mem_clk_en;
    endproperty
    a_idle: assert property (p_idle) else $error("command not idle early");
    property p_stable;
        mem_cmd == MPIS_CMD_MRL |-> cyc_r >= STABLE_CYC;
    endproperty
    a_stable: assert property (p_stable) else $error("load too early");
    property p_loads;
        mem_cmd == MPIS_CMD_MRL && mem_addr == '0 && $past(mem_cmd) == MPIS_CMD_NOP |=>
            mem_cmd == MPIS_CMD_MRL && mem_addr == '0 ##1
            mem_cmd == MPIS_CMD_MRL && mem_addr[MPIS_LOOP_RESET_POS];
    endproperty
    a_loads: assert property (p_loads) else $error("load series wrong");
    property p_refresh;
        mem_cmd == MPIS_CMD_MRL && mem_addr[MPIS_LOOP_RESET_POS] &&
            $past(mem_cmd) == MPIS_CMD_MRL |=> (mem_cmd == MPIS_CMD_NOP)[*6] ##1
            (mem_cmd == MPIS_CMD_REF && mem_bank == 3'h0) ##7
            (mem_cmd == MPIS_CMD_REF && mem_bank == 3'h7);
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh series wrong");
    property p_refaddr;
        mem_cmd == MPIS_CMD_REF |-> mem_addr == '0;
    endproperty
    a_refaddr: assert property (p_refaddr) else $error("refresh address set");
    property p_halves;
        acc |=> mem_cmd == MPIS_CMD_ACC && mem_addr[10:0] == $past(req_addr[10:0]) ##1
            mem_cmd == MPIS_CMD_NOP && mem_addr[10:0] == $past(req_addr[21:11], 2);
    endproperty
    a_halves: assert property (p_halves) else $error("address halves wrong");
    property p_wlat;
        acc && req_write |-> ##11 wdata_start;
    endproperty
    a_wlat: assert property (p_wlat) else $error("write data late");
    property p_rc;
        hit |-> age_r[mem_bank] >= MPIS_RC_CYC;
    endproperty
    a_rc: assert property (p_rc) else $error("bank reused too soon");
    property p_turn;
        mem_cmd == MPIS_CMD_ACC && mem_we |=> !(mem_cmd == MPIS_CMD_ACC && !mem_we)[*2];
    endproperty
    a_turn: assert property (p_turn) else $error("read too soon after write");
    property p_gate;
        req_ready |-> init_done;
    endproperty
    a_gate: assert property (p_gate) else $error("access before init");
    c_wr: cover property (acc && req_write);
    c_ref: cover property (mem_cmd == MPIS_CMD_REF && mem_bank == 3'h7);
    c_dll: cover property (mem_cmd == MPIS_CMD_MRL && !mem_addr[MPIS_LOOP_RESET_POS]);
endmodule // mpis_sequencer_chk
bind mpis_sequencer mpis_sequencer_chk #(.STABLE_CYC(STABLE_CYC),
    .DLL_LOCK_CYC(DLL_LOCK_CYC)) mpis_sequencer_chk_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .mode_word(mode_word), .clk_change(clk_change),
    .req_valid(req_valid), .req_write(req_write), .req_bank(req_bank),
    .req_addr(req_addr), .req_ready(req_ready), .init_done(init_done),
    .mem_clk_en(mem_clk_en), .mem_cmd(mem_cmd), .mem_we(mem_we), .mem_bank(mem_bank),
    .mem_addr(mem_addr), .wdata_start(wdata_start));

// ==== testbench/mpis_sequencer_bench.sv ====
`timescale 1ns/1ps
module mpis_sequencer_bench;
    import mpis_pkg::*;
    localparam int STB = 10;
    localparam int DLL = 4;
    logic clk_sys, sys_rst, clk_change, req_valid, req_write, req_ready, init_done;
    logic mem_clk_en, mem_we, wdata_start;
    logic [2:0] req_bank, mem_bank;
    logic [21:0] req_addr, acc_addr;
    logic [17:0] mode_word, mem_addr, mode_r;
    logic [7:0] n_loads, n_refs, wlat;
    mpis_cmd_t mem_cmd;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc;
    mpis_sequencer #(.STABLE_CYC(STB), .DLL_LOCK_CYC(DLL)) mpis_sequencer_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .mode_word(mode_word),
        .clk_change(clk_change), .req_valid(req_valid), .req_write(req_write),
        .req_bank(req_bank), .req_addr(req_addr), .req_ready(req_ready),
        .init_done(init_done), .mem_clk_en(mem_clk_en), .mem_cmd(mem_cmd),
        .mem_we(mem_we), .mem_bank(mem_bank), .mem_addr(mem_addr),
        .wdata_start(wdata_start));
    mpis_mem_model mpis_mem_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .mem_clk_en(mem_clk_en), .mem_cmd(mem_cmd), .mem_we(mem_we), .mem_bank(mem_bank),
        .mem_addr(mem_addr), .wdata_start(wdata_start), .n_loads(n_loads),
        .n_refs(n_refs), .acc_addr(acc_addr), .mode_r(mode_r), .wlat(wlat));
    // ----------------------------------------------------------------
    // clock, cycle count and checking helpers
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= sys_rst ? 0 : cyc + 1;
    task automatic chk(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // request held until the edge that samples ready high
    task automatic acc(input logic w, input logic [2:0] b, input logic [21:0] a,
                       output int t);
        int k;
        k = 0;
        req_valid <= 1'b1;
        req_write <= w;
        req_bank <= b;
        req_addr <= a;
        @(posedge clk_sys);
        while (req_ready !== 1'b1 && k < 2000) begin
            @(posedge clk_sys);
            k++;
        end
        t = cyc;
        chk(k < 2000, "request never taken");
    endtask
    task automatic pair(input logic w1, input logic [2:0] b1, input logic w2,
                        input logic [2:0] b2, input int g);
        int t1, t2;
        acc(w1, b1, 22'h15a3c7, t1);
        acc(w2, b2, 22'h2c1e5b, t2);
        req_valid <= 1'b0;
        chk(t2 - t1 >= g, "access spacing short");
        repeat (12) @(posedge clk_sys);
    endtask
    task automatic t_init;
        int t;
        chk(init_done === 1'b0, "init flag high early");
        acc(1'b0, 3'h0, 22'h001234, t);
        req_valid <= 1'b0;
        chk(init_done === 1'b1, "init flag low at access");
        chk(n_loads === 8'd3, "init load count");
        chk(mode_r === (mode_word | 18'h00080), "valid load value");
        chk(n_refs === 8'd8, "init refresh count");
        chk(t >= STB + 2 + MPIS_MRSC_CYC + MPIS_IDLE_CMDS, "access too early");
        repeat (12) @(posedge clk_sys);
    endtask
    task automatic t_halves;
        int t;
        acc(1'b1, 3'h1, 22'h2d5a3c, t);
        req_valid <= 1'b0;
        repeat (12) @(posedge clk_sys);
        chk(acc_addr === 22'h2d5a3c, "address halves");
        chk(wlat === 8'(MPIS_WRLAT_CYC), "write latency");
    endtask
    task automatic t_loop;
        int t0, t;
        logic [7:0] n0;
        n0 = n_loads;
        clk_change <= 1'b1;
        @(posedge clk_sys);
        clk_change <= 1'b0;
        t0 = cyc;
        acc(1'b0, 3'h6, 22'h0a5f0f, t);
        req_valid <= 1'b0;
        chk(n_loads === n0 + 8'd2, "loop reset loads");
        chk(mode_r[MPIS_LOOP_RESET_POS] === 1'b1, "loop bit high");
        chk(t - t0 >= MPIS_MRSC_CYC + DLL, "read before lock");
    endtask
    initial begin
        sys_rst <= 1'b1;
        {clk_change, req_valid, req_write, req_bank, req_addr} <= '0;
        mode_word <= 18'h00125;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_init;
        t_halves;
        pair(1'b1, 3'h2, 1'b1, 3'h2, MPIS_RC_CYC);
        pair(1'b0, 3'h3, 1'b0, 3'h3, MPIS_RC_CYC);
        pair(1'b1, 3'h4, 1'b0, 3'h5, 3);
        pair(1'b1, 3'h5, 1'b1, 3'h6, 2);
        t_loop;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        conclude;
    end
endmodule // mpis_sequencer_bench
